// [hw/acml_amp_chan.sv]
// One amplifier channel: decodes its control register into analog controls.
// Assumes the switching level is already on the reference clock domain.
`timescale 1ns/100ps
module acml_amp_chan (
  // Clock and reset.
  input  wire logic                        ref_clk,
  input  wire logic                        rst_n,
  // Register image and the selected timer level.
  input  wire logic [31:0]                 ctrlReg,
  input  wire logic                        swLevel,
  // Decoded controls, registered.
  output acml_pkg::acml_amp_ctrl_type      ampCtrl
);
  import acml_pkg::*;

  acml_amp_ctrl_type   ctrl_q;    // Registered controls.
  acml_amp_ctrl_type   ctrl_d;    // Next controls.
  logic                useSec;    // Secondary selections are in force.
  logic [POS_W-1:0]    posCode;   // Positive code chosen.
  logic [NEG_W-1:0]    negCode;   // Negative code chosen.
  logic [GAIN_W-1:0]   gainCode;  // Raw gain code.

  // Work out the next controls from the register and the timer level.
  always_comb begin
    useSec   = ctrlReg[SW_EN_BIT] & swLevel;
    posCode  = useSec ? ctrlReg[POS_SEC_LSB +: POS_W]
                      : ctrlReg[POS_PRI_LSB +: POS_W];
    negCode  = useSec ? ctrlReg[NEG_SEC_LSB +: NEG_W]
                      : ctrlReg[NEG_PRI_LSB +: NEG_W];
    gainCode = ctrlReg[GAIN_LSB +: GAIN_W];
    ctrl_d   = '0;
    ctrl_d.secondary = useSec;
    ctrl_d.enable    = ctrlReg[EN_BIT];
    ctrl_d.calMode   = ctrlReg[CAL_BIT];
    ctrl_d.highRange = ctrlReg[RANGE_BIT];
    // Codes past the real inputs leave every switch open.
    for (int i = 0; i < POS_NUM; i++) begin
      if (posCode == POS_W'(i)) begin
        ctrl_d.posSel[i] = 1'b1;
      end
    end
    for (int i = 0; i < NEG_NUM; i++) begin
      if (negCode == NEG_W'(i)) begin
        ctrl_d.negSel[i] = 1'b1;
      end
    end
    if (gainCode <= GAIN_MAX_CODE) begin
      ctrl_d.gainLog2 = gainCode + GAIN_DEF_LOG2;
    end else begin
      ctrl_d.gainLog2 = GAIN_DEF_LOG2;
    end
    case (ctrlReg[MODE_LSB +: MODE_W])
      MODE_CODE_PGA: ctrl_d.mode = MODE_PGA;
      MODE_CODE_FOL: ctrl_d.mode = MODE_FOLLOW;
      default:       ctrl_d.mode = MODE_EXT;
    endcase
  end

  // Register the controls so the analog side sees glitch-free levels.
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      ctrl_q <= '0;
    end else begin
      ctrl_q <= ctrl_d;
    end
  end

  assign ampCtrl = ctrl_q;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  // Switching off keeps the primary positive selection.
  prim_when_off_a: assert property (
    !ctrlReg[SW_EN_BIT] |=> !ctrl_q.secondary &&
      (ctrl_q.posSel[0] == ($past(ctrlReg[POS_PRI_LSB +: POS_W]) == 3'h0)))
    else $error("primary input not used while switching is off");
  // Secondary selection follows enable and level together.
  sec_select_a: assert property (
    ctrlReg[SW_EN_BIT] && swLevel |=> ctrl_q.secondary)
    else $error("secondary input not taken on timer high");
  // Unknown gain codes fall back to gain two.
  gain_default_a: assert property (
    ctrlReg[GAIN_LSB +: GAIN_W] > GAIN_MAX_CODE |=>
      ctrl_q.gainLog2 == GAIN_DEF_LOG2)
    else $error("gain fallback wrong");
  // A floating negative code opens every negative switch.
  neg_float_a: assert property (
    !useSec && ctrlReg[NEG_PRI_LSB +: NEG_W] == 2'h3 |=> ctrl_q.negSel == '0)
    else $error("negative input not floating");
  // Unconnected positive codes open every positive switch.
  pos_open_a: assert property (
    useSec && ctrlReg[POS_SEC_LSB +: POS_W] > 3'h3 |=> ctrl_q.posSel == '0)
    else $error("positive input not open");
  // Follower code drives follower mode.
  mode_follow_a: assert property (
    ctrlReg[MODE_LSB +: MODE_W] == MODE_CODE_FOL |=>
      ctrl_q.mode == MODE_FOLLOW)
    else $error("follower mode not decoded");
endmodule

// [hw/acml_pkg.sv]
// Constants, register map and carrier types for the amplifier control block.
// Assumes a single 20 MHz clock shared with the register port and timers.
package acml_pkg;

  // Register byte offsets.
  localparam logic [7:0] OFS_CS1  = 8'h00;
  localparam logic [7:0] OFS_CS2  = 8'h10;
  localparam logic [7:0] OFS_LOCK = 8'h20;

  // Reset values and writable bit masks.
  localparam logic [31:0] CS_RST    = 32'h0000_0000;
  localparam logic [31:0] CS1_WMASK = 32'h003F_8FFF;
  localparam logic [31:0] CS2_WMASK = 32'h013F_8FFF;
  localparam logic [1:0]  LOCK_RST  = 2'h0;

  // Field positions inside a control register.
  localparam int EN_BIT      = 0;
  localparam int MODE_LSB    = 1;
  localparam int GAIN_LSB    = 3;
  localparam int NEG_PRI_LSB = 6;
  localparam int POS_PRI_LSB = 8;
  localparam int CAL_BIT     = 11;
  localparam int CALRES_BIT  = 14;
  localparam int RANGE_BIT   = 15;
  localparam int SW_EN_BIT   = 16;
  localparam int NEG_SEC_LSB = 17;
  localparam int POS_SEC_LSB = 19;
  localparam int SRC_BIT     = 24;
  localparam int LOCK1_BIT   = 0;
  localparam int LOCK2_BIT   = 1;

  // Field widths and counts of real inputs.
  localparam int POS_W   = 3;
  localparam int NEG_W   = 2;
  localparam int GAIN_W  = 3;
  localparam int MODE_W  = 2;
  localparam int POS_NUM = 4;
  localparam int NEG_NUM = 3;

  // Codes with special meaning.
  localparam logic [GAIN_W-1:0] GAIN_MAX_CODE = 3'h4;
  localparam logic [GAIN_W-1:0] GAIN_DEF_LOG2 = 3'h1;
  localparam logic [MODE_W-1:0] MODE_CODE_PGA = 2'h2;
  localparam logic [MODE_W-1:0] MODE_CODE_FOL = 2'h3;

  // Operating mode as seen by the analog front end.
  typedef enum logic [1:0] {
    MODE_EXT,
    MODE_PGA,
    MODE_FOLLOW
  } acml_mode_type;

  // One register access from software.
  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } acml_bus_type;

  // Decoded control for one amplifier.
  typedef struct packed {
    logic               enable;
    logic               calMode;
    logic               highRange;
    acml_mode_type      mode;
    logic [POS_NUM-1:0] posSel;
    logic [NEG_NUM-1:0] negSel;
    logic [GAIN_W-1:0]  gainLog2;
    logic               secondary;
  } acml_amp_ctrl_type;

endpackage

// [hw/acml_top.sv]
// Register bank and input switching control for two amplifiers.
// Assumes timer levels come from logic on ref_clk; the calibration
// comparators are asynchronous and are synchronised here.
//
// The plain strobed port was decided locally.
`timescale 1ns/100ps
module acml_top #(
  parameter int CAL_SYNC = 2  // Synchroniser depth for comparators.
) (
  // Clock and reset.
  input  wire logic                        ref_clk,
  input  wire logic                        rst_n,
  // Register port.
  input  wire acml_pkg::acml_bus_type      busReq,
  output logic [31:0]                      rdData,
  // Timer channel levels.
  input  wire logic                        timer_a_ch6_level,
  input  wire logic                        timer_b_ch6_level,
  // Calibration comparator outputs, asynchronous.
  input  wire logic [1:0]                  calCmpRaw,
  // Decoded amplifier controls.
  output acml_pkg::acml_amp_ctrl_type      amp1Ctrl,
  output acml_pkg::acml_amp_ctrl_type      amp2Ctrl
);
  import acml_pkg::*;

  // Fewer than two stages would let a metastable level reach software.
  if (CAL_SYNC < 2) begin : gen_bad_sync
    $error("CAL_SYNC must be at least two");
  end

  logic [31:0] cs1_q;     // Amplifier 1 control register.
  logic [31:0] cs1_d;     // Its next value.
  logic [31:0] cs2_q;     // Amplifier 2 control register.
  logic [31:0] cs2_d;     // Its next value.
  logic [1:0]  lock_q;    // Write protection bits.
  logic [1:0]  lock_d;    // Their next value.
  logic [31:0] rdData_q;  // Read data register.
  logic [31:0] rdData_d;  // Next read data.
  logic [1:0]  calSync_q [CAL_SYNC];  // Comparator synchroniser.
  logic [1:0]  calRes;    // Synchronised comparator levels.
  logic        selCs1;    // Address hits amplifier 1.
  logic        selCs2;    // Address hits amplifier 2.
  logic        selLock;   // Address hits the lock register.
  logic        sw1Level;  // Switching level for amplifier 1.
  logic        sw2Level;  // Switching level for amplifier 2.

  // Address decode shared by reads and writes.
  always_comb begin
    selCs1  = busReq.addr == OFS_CS1;
    selCs2  = busReq.addr == OFS_CS2;
    selLock = busReq.addr == OFS_LOCK;
  end

  // Next values of the control and lock registers.
  always_comb begin
    cs1_d  = cs1_q;
    cs2_d  = cs2_q;
    lock_d = lock_q;
    if (busReq.wr && selCs1 && !lock_q[LOCK1_BIT]) begin
      cs1_d = busReq.wdata & CS1_WMASK;
    end
    if (busReq.wr && selCs2 && !lock_q[LOCK2_BIT]) begin
      cs2_d = busReq.wdata & CS2_WMASK;
    end
    if (busReq.wr && selLock) begin
      lock_d = lock_q | busReq.wdata[LOCK2_BIT:LOCK1_BIT];
    end
  end

  // Control and lock registers; only reset clears the lock.
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      cs1_q  <= CS_RST;
      cs2_q  <= CS_RST;
      lock_q <= LOCK_RST;
    end else begin
      cs1_q  <= cs1_d;
      cs2_q  <= cs2_d;
      lock_q <= lock_d;
    end
  end

  // Comparator synchroniser; only the last stage is read by logic.
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      for (int i = 0; i < CAL_SYNC; i++) begin
        calSync_q[i] <= 2'h0;
      end
    end else begin
      calSync_q[0] <= calCmpRaw;
      for (int i = 1; i < CAL_SYNC; i++) begin
        calSync_q[i] <= calSync_q[i-1];
      end
    end
  end

  assign calRes = calSync_q[CAL_SYNC-1];

  // Read mux; unmapped addresses return zero.
  always_comb begin
    rdData_d = rdData_q;
    if (busReq.rd) begin
      rdData_d = 32'h0000_0000;
      if (selCs1) begin
        rdData_d = cs1_q;
        rdData_d[CALRES_BIT] = calRes[0];
      end else if (selCs2) begin
        rdData_d = cs2_q;
        rdData_d[CALRES_BIT] = calRes[1];
      end else if (selLock) begin
        rdData_d[LOCK2_BIT:LOCK1_BIT] = lock_q;
      end
    end
  end

  // Read data holds its last value between reads.
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      rdData_q <= 32'h0000_0000;
    end else begin
      rdData_q <= rdData_d;
    end
  end

  assign rdData = rdData_q;

  // Switching level per amplifier.
  always_comb begin
    sw1Level = timer_a_ch6_level;
    sw2Level = cs2_q[SRC_BIT] ? timer_b_ch6_level : timer_a_ch6_level;
  end

  // Amplifier 1 decoder.
  acml_amp_chan u_amp1 (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .ctrlReg (cs1_q),
    .swLevel (sw1Level),
    .ampCtrl (amp1Ctrl)
  );

  // Amplifier 2 decoder.
  acml_amp_chan u_amp2 (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .ctrlReg (cs2_q),
    .swLevel (sw2Level),
    .ampCtrl (amp2Ctrl)
  );

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  // A write to amplifier 1 while locked.
  sequence lockedWr1;
    busReq.wr && selCs1 && lock_q[LOCK1_BIT];
  endsequence
  // An open write to amplifier 2 followed by its read.
  sequence openWrRd2;
    busReq.wr && selCs2 && !lock_q[LOCK2_BIT] ##1 busReq.rd && selCs2;
  endsequence

  // Locked register keeps its value across the write.
  locked_write_a: assert property (
    lockedWr1 |=> $stable(cs1_q))
    else $error("locked register changed on write");
  // A set amplifier 2 lock bit stays set for the next eight cycles.
  lock_holds_a: assert property (
    lock_q[LOCK2_BIT] |=> lock_q[LOCK2_BIT] [*8])
    else $error("lock bit cleared without reset");
  // Writing a one to bit one locks amplifier 2.
  lock_set_a: assert property (
    busReq.wr && selLock && busReq.wdata[LOCK2_BIT] |=> lock_q[LOCK2_BIT])
    else $error("lock bit not set");
  // Written value read back masked, one cycle after the read.
  write_read_a: assert property (
    openWrRd2 |=> rdData[31:25] == 7'h00 &&
      rdData[SRC_BIT] == $past(busReq.wdata[SRC_BIT], 2))
    else $error("readback does not match write");
  // Amplifier 2 source bit routes timer B.
  src_timer_b_a: assert property (
    cs2_q[SRC_BIT] && cs2_q[SW_EN_BIT] && timer_b_ch6_level |=>
      amp2Ctrl.secondary)
    else $error("timer B level not followed");
  // Calibration bit shows the synchronised comparator.
  cal_read_a: assert property (
    busReq.rd && selCs1 |=> rdData[CALRES_BIT] == $past(calRes[0]))
    else $error("calibration result not reflected");
  // Unmapped reads return zero.
  unmapped_zero_a: assert property (
    busReq.rd && !selCs1 && !selCs2 && !selLock |=> rdData == 32'h0000_0000)
    else $error("unmapped read not zero");
  // Locked amplifier 2 writes are dropped too.
  locked_write2_a: assert property (
    busReq.wr && selCs2 && lock_q[LOCK2_BIT] |=> $stable(cs2_q))
    else $error("locked amplifier 2 register changed");
endmodule

// [tb/acml_partner_model.sv]
// Far side of the amplifier block: two timer channel-6 outputs and two
// calibration comparators. Assumes commands arrive from the bench.
`timescale 1ns/100ps
module acml_partner_model (
  // Clock.
  input  wire logic       ref_clk,
  // Commands from the bench.
  input  wire logic       levelACmd,
  input  wire logic       levelBCmd,
  input  wire logic [1:0] calCmd,
  // Timer levels and comparator outputs.
  output logic            timerA,
  output logic            timerB,
  output logic [1:0]      calibration_result
);
  // Timers run on the same clock, so levels change just after an edge.
  always_ff @(posedge ref_clk) begin
    timerA <= levelACmd;
    timerB <= levelBCmd;
  end

  // Start the comparators low; an unknown level would spoil every control register readback.
  initial begin
    calibration_result = 2'h0;
  end

  // The comparators are analog and settle off the clock grid on purpose.
  always @(calCmd) begin
    calibration_result <= #17 calCmd;
  end
endmodule

// [tb/tb_top.sv]
// Self-checking bench for the amplifier control register bank.
// Assumes one 20 MHz clock and a register port with one-cycle strobes.
`timescale 1ns/100ps
module tb_top;
  import acml_pkg::*;
  logic              ref_clk = 1'b0;   // Reference clock.
  logic              rst_n   = 1'b0;   // Synchronous reset.
  acml_bus_type      busReq  = '0;     // Register requests.
  logic [31:0]       rdData;           // Read data.
  logic              tmrA, tmrB;       // Timer levels from the partner.
  logic [1:0]        calRaw;           // Comparator outputs.
  logic              lvlA = 1'b0;      // Command for timer A.
  logic              lvlB = 1'b0;      // Command for timer B.
  logic [1:0]        calCmd = 2'h0;    // Command for comparators.
  acml_amp_ctrl_type amp1, amp2;       // Decoded controls.
  logic [31:0]       r1, r2;           // Last values written.
  int                fails  = 0;       // Mismatch counter.
  int                checks = 0;       // Comparison counter.

  // 50 ns period.
  always #25 ref_clk = ~ref_clk;

  acml_partner_model acml_partner_model_i (.ref_clk(ref_clk),
    .levelACmd(lvlA), .levelBCmd(lvlB), .calCmd(calCmd),
    .timerA(tmrA), .timerB(tmrB), .calibration_result(calRaw));

  acml_top acml_top_i (.ref_clk(ref_clk), .rst_n(rst_n), .busReq(busReq),
    .rdData(rdData), .timer_a_ch6_level(tmrA), .timer_b_ch6_level(tmrB),
    .calCmpRaw(calRaw), .amp1Ctrl(amp1), .amp2Ctrl(amp2));

  // Prints the counts and the verdict, then stops the run.
  task automatic finish_test;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // Compares one register word.
  task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Compares one decoded amplifier control word.
  task automatic chkAmp(input acml_amp_ctrl_type got,
                        input acml_amp_ctrl_type exp);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One-cycle write; a gap cycle follows so strobes never collide.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    busReq <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge ref_clk);
    busReq <= '0;
  endtask

  // One-cycle read; data are taken in the cycle after the strobe.
  task automatic rdChk(input logic [7:0] a, input logic [31:0] exp);
    @(posedge ref_clk);
    busReq <= '{addr: a, wdata: 32'h0000_0000, wr: 1'b0, rd: 1'b1};
    @(posedge ref_clk);
    busReq <= '0;
    #1;
    chk32(rdData, exp);
  endtask

  // Holds reset for twelve clock cycles.
  task automatic doReset;
    @(posedge ref_clk);
    rst_n <= 1'b0;
    repeat (12) @(posedge ref_clk);
    rst_n <= 1'b1;
  endtask

  // Lets the partner, the sampling edge and the output register settle.
  task automatic settle;
    repeat (4) @(posedge ref_clk);
    #1;
  endtask

  // Expected decode of a control word for a given switching level.
  function automatic acml_amp_ctrl_type expAmp(input logic [31:0] r,
                                               input logic lvl);
    acml_amp_ctrl_type e;
    logic              sec;
    logic [2:0]        p;
    logic [1:0]        n;
    logic [2:0]        g;
    sec = r[16] & lvl;
    p = sec ? r[21:19] : r[10:8];
    n = sec ? r[18:17] : r[7:6];
    g = r[5:3];
    e = '0;
    e.enable    = r[0];
    e.calMode   = r[11];
    e.highRange = r[15];
    e.mode = (r[2:1] == 2'h2) ? MODE_PGA :
             (r[2:1] == 2'h3) ? MODE_FOLLOW : MODE_EXT;
    // Codes beyond the real inputs leave the input open.
    e.posSel = (p < 3'h4) ? 4'(1 << p) : 4'h0;
    e.negSel = (n < 2'h3) ? 3'(1 << n) : 3'h0;
    // Unknown gain codes fall back to gain two.
    e.gainLog2  = (g <= 3'h4) ? g + 3'h1 : 3'h1;
    e.secondary = sec;
    return e;
  endfunction

  // Main sequence.
  initial begin
    logic [2:0] c;
    doReset();
    rdChk(OFS_CS1, 32'h0000_0000);
    rdChk(OFS_CS2, 32'h0000_0000);
    rdChk(OFS_LOCK, 32'h0000_0000);
    settle();
    chkAmp(amp1, expAmp(32'h0000_0000, 1'b0));
    // Reserved and read-only bits must ignore all-ones writes.
    wr(OFS_CS1, 32'hFFFF_FFFF);
    wr(OFS_CS2, 32'hFFFF_FFFF);
    wr(8'h30, 32'hFFFF_FFFF);
    rdChk(OFS_CS1, 32'h003F_8FFF);
    rdChk(OFS_CS2, 32'h013F_8FFF);
    rdChk(8'h30, 32'h0000_0000);
    // Every field code, with switching on and off, at both timer levels.
    for (int i = 0; i < 8; i++) begin
      c = 3'(i);
      r1 = 32'h0000_0000;
      r1[0] = c[0];
      r1[2:1] = c[1:0];
      r1[5:3] = c;
      r1[7:6] = ~c[1:0];
      r1[10:8] = ~c;
      r1[11] = c[1];
      r1[15] = c[2];
      r1[16] = c[0] | c[2];
      r1[18:17] = c[2:1];
      r1[21:19] = c + 3'h2;
      r2 = r1 | (c[1] ? 32'h0100_0000 : 32'h0000_0000);
      // Switching enable and source go in before the start.
      wr(OFS_CS1, r1);
      wr(OFS_CS2, r2);
      rdChk(OFS_CS1, r1);
      for (int l = 0; l < 2; l++) begin
        lvlA <= l[0];
        lvlB <= ~l[0];
        settle();
        chkAmp(amp1, expAmp(r1, l[0]));
        chkAmp(amp2, expAmp(r2, r2[24] ? ~l[0] : l[0]));
      end
    end
    // Comparator outputs reach bit 14 after synchronising.
    calCmd <= 2'h1;
    repeat (6) @(posedge ref_clk);
    rdChk(OFS_CS1, r1 | 32'h0000_4000);
    rdChk(OFS_CS2, r2);
    // Protection: set, attempt to clear, then add the second bit.
    wr(OFS_LOCK, 32'h0000_0001);
    wr(OFS_CS1, 32'h0000_0000);
    rdChk(OFS_CS1, r1 | 32'h0000_4000);
    wr(OFS_LOCK, 32'h0000_0000);
    rdChk(OFS_LOCK, 32'h0000_0001);
    wr(OFS_CS2, 32'h0000_0001);
    rdChk(OFS_CS2, 32'h0000_0001);
    wr(OFS_LOCK, 32'h0000_0002);
    rdChk(OFS_LOCK, 32'h0000_0003);
    wr(OFS_CS2, 32'h0000_0000);
    rdChk(OFS_CS2, 32'h0000_0001);
    settle();
    chkAmp(amp2, expAmp(32'h0000_0001, 1'b0));
    // Only a reset lifts the protection.
    doReset();
    rdChk(OFS_LOCK, 32'h0000_0000);
    wr(OFS_CS1, 32'h0000_0001);
    repeat (4) @(posedge ref_clk);
    rdChk(OFS_CS1, 32'h0000_4001);
    finish_test();
  end

  // Watchdog: the sequence needs well under 2000 cycles.
  initial begin
    repeat (5000) @(posedge ref_clk);
    fails++;
    finish_test();
  end
endmodule
